// >>> core/cuor_options_top.sv
/*
 * Converter user option word with its command port, nonvolatile image,
 * alert masking and the controls it steers.
 * Assumes commands are decoded by the bus engine on the same clock and
 * that the analog stages act on the control outputs.
 */
// Functional notes
// - Store-all command copies backed option bits into the nonvolatile image.
// - Negative-limit-disable bit one turns off low-side negative current limit.
// - Shared pin shows power good at zero, active-low reset at one.
// - Telemetry converter runs only while its enable bit is one.
// - With converter disabled, readbacks hold their last captured values.
// - Fast mode drops current and temperature, keeps only voltage readings.
// - Fast mode and override bits are never stored or restored.
// - Entering or leaving fast mode may lose one voltage sample.
// - Override bit lets out-of-range writes through without validity checks.
// - Invalid data under override sets no invalid flag and no alert.
// - Clearing override raises no alert for invalid values left behind.
// - Averaging field: 00 sixteen, 01 bypass, 10 eight, 11 thirty-two.
// - In bypass every sample updates its readback immediately.
// - Auto masking masks all set faults after a successful alert response.
// - Without auto masking alerts repeat; host masks sources itself.
// - Divider field forces half, quarter, eighth; zero follows loop scale.
// - Setpoint reset bit reloads default setpoint on any shutdown.
// - Margin-low restore bit selects fff7h or fff1h.
// - Margin-high restore bit selects 0009h or 000fh.
`timescale 1ns/1ps
`include "cuor_params.svh"
module cuor_options_top
    import cuor_pkg::*;
#(
    parameter int SAMPLE_W = 12
)(
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     cmd_valid_i,
    input  wire logic                     cmd_write_i,
    input  wire logic [7:0]               cmd_code_i,
    input  wire logic [15:0]              cmd_wdata_i,

    input  wire logic                     sample_valid_i,
    input  wire cuor_chan_t               sample_chan_i,
    input  wire logic [SAMPLE_W-1:0]      sample_data_i,

    input  wire logic                     power_good_indication_i,
    input  wire logic                     reset_n_src_i,
    input  wire cuor_scale_t              scale_loop_i,
    input  wire logic                     invalid_write_i,
    input  wire logic                     clear_faults_i,
    input  wire logic [`CUOR_FAULT_W-1:0] fault_src_i,
    input  wire logic [`CUOR_FAULT_W-1:0] host_mask_i,
    input  wire logic                     ara_done_i,
    input  wire logic                     shutdown_evt_i,

    output logic                          rd_valid_o,
    output logic [15:0]                   rd_data_o,
    output logic                          cmd_nack_o,

    output logic                          neg_ilim_en_o,
    output logic                          reset_or_power_good_pin_o,
    output logic                          adc_run_o,
    output logic                          fast_mode_o,
    output logic                          limit_override_o,
    output cuor_div_t                     vout_div_o,
    output logic                          invalid_data_flag_o,
    output logic                          alert_n_o,

    output logic                          setpoint_reload_o,
    output logic [15:0]                   margin_hi_restore_o,
    output logic [15:0]                   margin_lo_restore_o
);
    localparam int FW = `CUOR_FAULT_W + 1;

    typedef struct packed {
        logic [15:0]   opt;
        logic [15:0]   nv;
        logic [15:0]   rd_data;
        logic          rd_valid;
        logic          nack;

        logic          invalid_data_flag;
        logic [FW-1:0] auto_mask;
        logic          alert_n;

        logic          reload;
        logic          pin;
        logic          neg_en;
        logic          adc_run;
        logic          fast;
        logic          ovr;
        cuor_div_t     div;
        logic [15:0]   mhi;
        logic [15:0]   mlo;

        logic          up;
    } cuor_top_st_t;

    cuor_top_st_t st_r;
    cuor_top_st_t st_nxt;

    cuor_telem_if #(.W(SAMPLE_W)) tif ();

    cuor_telem_avg #(
        .W (SAMPLE_W)
    ) u_avg (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .tif       (tif.avg)
    );

    // Each nonzero field code forces its own divider; zero follows the loop scale.
    function automatic cuor_div_t div_pick(input logic [1:0] rng,
                                           input cuor_scale_t sc);
        case (rng)
            2'b11:   div_pick = CUOR_DIV_HALF;
            2'b10:   div_pick = CUOR_DIV_QUARTER;
            2'b01:   div_pick = CUOR_DIV_EIGHTH;
            default:
                case (sc)
                    CUOR_SCALE_ONE:  div_pick = CUOR_DIV_HALF;
                    CUOR_SCALE_HALF: div_pick = CUOR_DIV_QUARTER;
                    default:         div_pick = CUOR_DIV_EIGHTH;
                endcase
        endcase
    endfunction

    function automatic logic [15:0] widen(input logic [SAMPLE_W-1:0] v);
        widen = 16'(v);
    endfunction

    always_comb
    begin
        logic [FW-1:0] src;
        logic [FW-1:0] act;

        src = '0;
        act = '0;
        st_nxt = st_r;
        st_nxt.up = 1'b1;
        st_nxt.rd_valid = 1'b0;
        st_nxt.nack = 1'b0;

        if (cmd_valid_i)
        begin
            if (cmd_write_i)
            begin
                case (cmd_code_i)
                    `CUOR_CMD_OPTIONS:
                        st_nxt.opt = cmd_wdata_i & `CUOR_OPT_WR_MASK;
                    `CUOR_CMD_STORE_ALL:
                        st_nxt.nv = st_r.opt & `CUOR_OPT_NV_MASK;
                    `CUOR_CMD_RESTORE:
                        st_nxt.opt = (st_r.nv & `CUOR_OPT_NV_MASK)
                            | (st_r.opt & ~`CUOR_OPT_NV_MASK);
                    default:
                        st_nxt.nack = 1'b1;
                endcase
            end
            else
            begin
                st_nxt.rd_valid = 1'b1;
                case (cmd_code_i)
                    `CUOR_CMD_OPTIONS: st_nxt.rd_data = st_r.opt;
                    `CUOR_CMD_RD_VOUT: st_nxt.rd_data = widen(tif.vout_rb);
                    `CUOR_CMD_RD_IOUT: st_nxt.rd_data = widen(tif.iout_rb);
                    `CUOR_CMD_RD_TEMP: st_nxt.rd_data = widen(tif.temp_rb);
                    default:
                    begin
                        st_nxt.rd_valid = 1'b0;
                        st_nxt.nack = 1'b1;
                    end
                endcase
            end
        end

        st_nxt.neg_en = !st_nxt.opt[`CUOR_B_NEGILIM];
        st_nxt.pin = st_nxt.opt[`CUOR_B_RSTPIN]
            ? reset_n_src_i : power_good_indication_i;
        st_nxt.adc_run = st_nxt.opt[`CUOR_B_ADCEN];
        st_nxt.fast = st_nxt.opt[`CUOR_B_FAST];
        st_nxt.ovr = st_nxt.opt[`CUOR_B_OVR];

        st_nxt.div = div_pick(st_nxt.opt[`CUOR_B_DIV_HI:`CUOR_B_DIV_LO],
                              scale_loop_i);

        st_nxt.mlo = st_nxt.opt[`CUOR_B_MLO]
            ? `CUOR_MLO_VAL1 : `CUOR_MLO_VAL0;
        st_nxt.mhi = st_nxt.opt[`CUOR_B_MHI]
            ? `CUOR_MHI_VAL1 : `CUOR_MHI_VAL0;
        st_nxt.reload = shutdown_evt_i
            && st_r.opt[`CUOR_B_SPRST];

        // The flag is driven by events only, so dropping the override
        // later cannot raise it for data already written.
        if (clear_faults_i)
            st_nxt.invalid_data_flag = 1'b0;
        if (invalid_write_i && !st_r.opt[`CUOR_B_OVR])
            st_nxt.invalid_data_flag = 1'b1;

        src = {st_nxt.invalid_data_flag, fault_src_i};
        if (clear_faults_i)
            st_nxt.auto_mask = '0;
        if (ara_done_i && st_r.opt[`CUOR_B_ARA])
            st_nxt.auto_mask = st_nxt.auto_mask | src;
        // Without auto masking only the host mask can quiet a source.
        act = src & ~st_nxt.auto_mask & ~{1'b0, host_mask_i};
        st_nxt.alert_n = !(|act);
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= '0;
            st_r.opt <= `CUOR_OPT_RESET;
            st_r.nv <= `CUOR_OPT_RESET;

            st_r.alert_n <= 1'b1;
            st_r.pin <= 1'b0;
            st_r.adc_run <= 1'b1;
            st_r.neg_en <= 1'b1;
            st_r.mlo <= `CUOR_MLO_VAL0;
            st_r.mhi <= `CUOR_MHI_VAL0;
            st_r.div <= CUOR_DIV_EIGHTH;
        end
        else
            st_r <= st_nxt;
    end

    assign tif.adc_en = st_r.adc_run;
    assign tif.fast_mode = st_r.fast;
    assign tif.avg_sel = st_r.opt[`CUOR_B_AVG_HI:`CUOR_B_AVG_LO];

    assign tif.sample_valid = sample_valid_i;
    assign tif.sample_chan = sample_chan_i;
    assign tif.sample_data = sample_data_i;

    assign rd_valid_o = st_r.rd_valid;
    assign rd_data_o = st_r.rd_data;
    assign cmd_nack_o = st_r.nack;

    assign neg_ilim_en_o = st_r.neg_en;
    assign reset_or_power_good_pin_o = st_r.pin;
    assign adc_run_o = st_r.adc_run;
    assign fast_mode_o = st_r.fast;
    assign limit_override_o = st_r.ovr;
    assign vout_div_o = st_r.div;
    assign invalid_data_flag_o = st_r.invalid_data_flag;
    assign alert_n_o = st_r.alert_n;
    assign setpoint_reload_o = st_r.reload;
    assign margin_hi_restore_o = st_r.mhi;
    assign margin_lo_restore_o = st_r.mlo;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_NV_STORE: assert property (
        cmd_valid_i && cmd_write_i && cmd_code_i == `CUOR_CMD_STORE_ALL
        |=> st_r.nv == ($past(st_r.opt) & `CUOR_OPT_NV_MASK))
        else $error("store-all did not capture the backed bits");

    AST_NEG_LIMIT: assert property (
        st_r.up |-> neg_ilim_en_o == !st_r.opt[`CUOR_B_NEGILIM])
        else $error("negative limit enable disagrees with option");

    AST_PIN_FUNC: assert property (
        st_r.up && $past(st_r.up) |-> reset_or_power_good_pin_o ==
        (st_r.opt[`CUOR_B_RSTPIN] ? $past(reset_n_src_i) : $past(power_good_indication_i)))
        else $error("shared pin shows the wrong function");

    AST_RESTORE_KEEP: assert property (
        cmd_valid_i && cmd_write_i && cmd_code_i == `CUOR_CMD_RESTORE
        |=> st_r.opt[`CUOR_B_OVR:`CUOR_B_FAST]
            == $past(st_r.opt[`CUOR_B_OVR:`CUOR_B_FAST]))
        else $error("restore touched unbacked bits");

    AST_IVD_OVR: assert property (
        st_r.opt[`CUOR_B_OVR] && invalid_write_i && !st_r.invalid_data_flag
        |=> !st_r.invalid_data_flag)
        else $error("invalid flag set under override");

    AST_AUTO_MASK: assert property (
        ara_done_i && st_r.opt[`CUOR_B_ARA] && !clear_faults_i
        && fault_src_i[0] |=> st_r.auto_mask[0] ##1 st_r.auto_mask[0]
        || $past(clear_faults_i))
        else $error("fault not masked after alert response");

    AST_DIV_FORCE: assert property (
        st_r.opt[`CUOR_B_DIV_HI:`CUOR_B_DIV_LO] == 2'b01
        |-> vout_div_o == CUOR_DIV_EIGHTH)
        else $error("divider not forced to one eighth");

    AST_RELOAD: assert property (
        shutdown_evt_i && st_r.opt[`CUOR_B_SPRST]
        |=> setpoint_reload_o ##1 !setpoint_reload_o || $past(shutdown_evt_i))
        else $error("setpoint reload pulse missing");

    AST_MARGIN: assert property (
        margin_lo_restore_o == (st_r.opt[`CUOR_B_MLO]
            ? `CUOR_MLO_VAL1 : `CUOR_MLO_VAL0)
        && margin_hi_restore_o == (st_r.opt[`CUOR_B_MHI]
            ? `CUOR_MHI_VAL1 : `CUOR_MHI_VAL0))
        else $error("margin restore value wrong");

    AST_WR_MASK: assert property (
        cmd_valid_i && cmd_write_i && cmd_code_i == `CUOR_CMD_OPTIONS
        |=> st_r.opt == ($past(cmd_wdata_i) & `CUOR_OPT_WR_MASK))
        else $error("option write not masked");

    AST_BYPASS: assert property (
        st_r.adc_run && tif.avg_sel == `CUOR_AVG_BYPASS && !st_r.fast
        && sample_valid_i && sample_chan_i == CUOR_CHAN_IOUT
        |=> tif.iout_rb == $past(sample_data_i))
        else $error("bypass sample did not reach readback");

    AST_HOLD: assert property (
        !st_r.adc_run |=> $stable(tif.vout_rb) && $stable(tif.temp_rb))
        else $error("readback moved while converter disabled");

    AST_CTRL_MAP: assert property (
        adc_run_o == st_r.opt[`CUOR_B_ADCEN]
        && fast_mode_o == st_r.opt[`CUOR_B_FAST]
        && limit_override_o == st_r.opt[`CUOR_B_OVR])
        else $error("control output wrong");

    AST_ALERT_ON: assert property (
        fault_src_i[0] && !host_mask_i[0] && !st_r.opt[`CUOR_B_ARA]
        && st_r.auto_mask == '0 |=> !alert_n_o)
        else $error("fault lost its alert");

    COV_STORE: cover property (
        cmd_valid_i && cmd_write_i && cmd_code_i == `CUOR_CMD_STORE_ALL);
    COV_RESTORE: cover property (
        cmd_valid_i && cmd_write_i && cmd_code_i == `CUOR_CMD_RESTORE);
    COV_AUTO_ARA: cover property (
        ara_done_i && st_r.opt[`CUOR_B_ARA] && !alert_n_o ##1 alert_n_o);
    COV_BYPASS: cover property (
        tif.avg_sel == `CUOR_AVG_BYPASS && tif.adc_en && sample_valid_i);
    COV_RELOAD: cover property (
        setpoint_reload_o);
endmodule // cuor_options_top

// >>> core/cuor_params.svh
/*
 * Constants of the converter user option register: command codes,
 * bit positions, masks, reset and restore values.
 * Assumes inclusion by the option register and its telemetry averager.
 */
`ifndef CUOR_PARAMS_SVH
`define CUOR_PARAMS_SVH

`define CUOR_CMD_OPTIONS   8'hE5
`define CUOR_CMD_STORE_ALL 8'h11
`define CUOR_CMD_RESTORE   8'h12
`define CUOR_CMD_RD_VOUT   8'h8B
`define CUOR_CMD_RD_IOUT   8'h8C
`define CUOR_CMD_RD_TEMP   8'h8D

`define CUOR_OPT_RESET     16'h0184
`define CUOR_OPT_WR_MASK   16'h6BFF
`define CUOR_OPT_NV_MASK   16'h6BE7

`define CUOR_B_NEGILIM     0
`define CUOR_B_RSTPIN      1
`define CUOR_B_ADCEN       2
`define CUOR_B_FAST        3
`define CUOR_B_OVR         4
`define CUOR_B_AVG_LO      5
`define CUOR_B_AVG_HI      6
`define CUOR_B_ARA         7
`define CUOR_B_DIV_LO      8
`define CUOR_B_DIV_HI      9
`define CUOR_B_SPRST       11
`define CUOR_B_MLO         13
`define CUOR_B_MHI         14

`define CUOR_MLO_VAL0      16'hFFF7
`define CUOR_MLO_VAL1      16'hFFF1
`define CUOR_MHI_VAL0      16'h0009
`define CUOR_MHI_VAL1      16'h000F

`define CUOR_AVG_BYPASS    2'h1
`define CUOR_FAULT_W       8

`endif

// >>> core/cuor_pkg.sv
/*
 * Types shared by the option register and its telemetry averager.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cuor_pkg;

    typedef enum logic [1:0] {
        CUOR_DIV_HALF    = 2'b00,
        CUOR_DIV_QUARTER = 2'b01,
        CUOR_DIV_EIGHTH  = 2'b10
    } cuor_div_t;

    typedef enum logic [1:0] {
        CUOR_SCALE_ONE     = 2'b00,
        CUOR_SCALE_HALF    = 2'b01,
        CUOR_SCALE_QUARTER = 2'b10
    } cuor_scale_t;

    typedef enum logic [1:0] {
        CUOR_CHAN_VOUT = 2'b00,
        CUOR_CHAN_IOUT = 2'b01,
        CUOR_CHAN_TEMP = 2'b10
    } cuor_chan_t;

endpackage

// >>> core/cuor_telem_if.sv
/*
 * Carrier between the option register and the telemetry averager:
 * control bits and raw samples one way, readback words the other.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface cuor_telem_if
    import cuor_pkg::*;
#(
    parameter int W = 12
);
    logic             adc_en;
    logic             fast_mode;
    logic [1:0]       avg_sel;
    logic             sample_valid;
    cuor_chan_t       sample_chan;
    logic [W-1:0]     sample_data;
    logic [W-1:0]     vout_rb;
    logic [W-1:0]     iout_rb;
    logic [W-1:0]     temp_rb;

    modport ctl (output adc_en, fast_mode, avg_sel, sample_valid,
                 sample_chan, sample_data,
                 input  vout_rb, iout_rb, temp_rb);
    modport avg (input  adc_en, fast_mode, avg_sel, sample_valid,
                 sample_chan, sample_data,
                 output vout_rb, iout_rb, temp_rb);
endinterface // cuor_telem_if

// >>> core/cuor_telem_avg.sv
/*
 * Telemetry averager: accumulates raw converter samples per channel
 * and publishes the averaged readback words.
 * Assumes samples arrive on the same clock as the option register.
 */
`timescale 1ns/1ps
`include "cuor_params.svh"
module cuor_telem_avg
    import cuor_pkg::*;
#(
    parameter int W = 12
)(
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    cuor_telem_if.avg tif
);
    localparam int AW = W + 5;

    typedef struct packed {
        logic [2:0][AW-1:0] acc;
        logic [2:0][5:0]    cnt;
        logic [2:0][W-1:0]  rb;
        logic               fast_q;
        logic               drop;
    } cuor_avg_st_t;

    cuor_avg_st_t st_r;
    cuor_avg_st_t st_nxt;

    function automatic logic [2:0] depth_shift(input logic [1:0] sel);
        case (sel)
            2'b00:   depth_shift = 3'd4;
            2'b01:   depth_shift = 3'd0;
            2'b10:   depth_shift = 3'd3;
            default: depth_shift = 3'd5;
        endcase
    endfunction

    always_comb
    begin
        logic [1:0]    c;
        logic [2:0]    sh;
        logic [AW-1:0] sum;
        logic          take;
        logic          lose;
        st_nxt = st_r;
        c = tif.sample_chan;
        sh = depth_shift(tif.avg_sel);
        // Outside bypass, a mode change costs the next voltage sample, still counted.
        st_nxt.fast_q = tif.fast_mode;
        if (tif.fast_mode != st_r.fast_q)
            st_nxt.drop = 1'b1;
        take = tif.sample_valid && tif.adc_en && c != 2'b11
            && (c == CUOR_CHAN_VOUT || !tif.fast_mode);
        lose = st_nxt.drop && c == CUOR_CHAN_VOUT && sh != 3'd0;
        sum = (sh == 3'd0) ? '0 : st_r.acc[c];
        if (!lose)
            sum = sum + AW'(tif.sample_data);
        if (take)
        begin
            if (c == CUOR_CHAN_VOUT)
                st_nxt.drop = 1'b0;
            if (st_r.cnt[c] + 6'd1 >= (6'd1 << sh))
            begin
                st_nxt.rb[c] = W'(sum >> sh);
                st_nxt.acc[c] = '0;
                st_nxt.cnt[c] = '0;
            end
            else
            begin
                st_nxt.acc[c] = sum;
                st_nxt.cnt[c] = st_r.cnt[c] + 6'd1;
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tif.vout_rb = st_r.rb[0];
    assign tif.iout_rb = st_r.rb[1];
    assign tif.temp_rb = st_r.rb[2];
endmodule // cuor_telem_avg

// >>> sim/cuor_host_model.sv
/*
 * Host model for the option register: issues one command at a time on
 * the command port and captures the registered answer.
 * Assumes the block's clock and an answer one cycle after the take edge.
 */
`timescale 1ns/1ps
module cuor_host_model (
    input  wire logic        ref_clk_i,
    input  wire logic        rd_valid_i,
    input  wire logic        cmd_nack_i,
    input  wire logic [15:0] rd_data_i,
    output logic             cmd_valid_o,
    output logic             cmd_write_o,
    output logic [7:0]       cmd_code_o,
    output logic [15:0]      cmd_wdata_o
);
    logic [15:0] rd_word;
    logic        rd_seen;
    logic        nack_seen;

    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_code_o  = 8'h00;
        cmd_wdata_o = 16'h0000;
    end

    // Released code and data lines carry the inverse word so stale data cannot match.
    task automatic send(input logic w, input logic [7:0] c,
                        input logic [15:0] d);
        @(posedge ref_clk_i);
        cmd_valid_o <= 1'b1;
        cmd_write_o <= w;
        cmd_code_o  <= c;
        cmd_wdata_o <= d;
        @(posedge ref_clk_i);
        cmd_valid_o <= 1'b0;
        cmd_code_o  <= ~c;
        cmd_wdata_o <= ~d;
        @(posedge ref_clk_i);
        rd_word   = rd_data_i;
        rd_seen   = rd_valid_i;
        nack_seen = cmd_nack_i;
    endtask
endmodule // cuor_host_model

// >>> sim/cuor_options_top_tb_top.sv
/*
 * Self-checking bench of the option register: averaging, hold, fast
 * mode, store and restore, random option words, alerts and reloads.
 * Assumes the design files and the host model are compiled first.
 */
`timescale 1ns/1ps
`include "cuor_params.svh"
module cuor_options_top_tb_top
    import cuor_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic        smp_v;
    cuor_chan_t  smp_ch;
    logic [11:0] smp_d;
    logic        power_good_indication;
    logic        rsrc;
    cuor_scale_t scale;
    logic [3:0]  ev;
    logic [7:0]  fault;
    logic [7:0]  hmask;
    logic        cv;
    logic        cw;
    logic [7:0]  cc;
    logic [15:0] cd;
    logic        rdv;
    logic        nack;
    logic [15:0] rdd;
    logic        nil;
    logic        pin;
    logic        adc;
    logic        fast;
    logic        ovr;
    cuor_div_t   div;
    logic        invalid_data_flag;
    logic        alrt;
    logic        rld;
    logic [15:0] mhi;
    logic [15:0] mlo;
    logic [31:0] seed;
    logic [11:0] rb [3];
    int          err_total = 0;
    int          check_count = 0;
    int          cyc_n = 0;

    cuor_options_top #(.SAMPLE_W(12)) cuor_options_top_i (
        .ref_clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cv),
        .cmd_write_i(cw), .cmd_code_i(cc), .cmd_wdata_i(cd),
        .sample_valid_i(smp_v), .sample_chan_i(smp_ch),
        .sample_data_i(smp_d), .power_good_indication_i(power_good_indication), .reset_n_src_i(rsrc),
        .scale_loop_i(scale), .invalid_write_i(ev[2]),
        .clear_faults_i(ev[1]), .fault_src_i(fault), .host_mask_i(hmask),
        .ara_done_i(ev[0]), .shutdown_evt_i(ev[3]), .rd_valid_o(rdv),
        .rd_data_o(rdd), .cmd_nack_o(nack), .neg_ilim_en_o(nil),
        .reset_or_power_good_pin_o(pin), .adc_run_o(adc),
        .fast_mode_o(fast), .limit_override_o(ovr), .vout_div_o(div),
        .invalid_data_flag_o(invalid_data_flag), .alert_n_o(alrt),
        .setpoint_reload_o(rld), .margin_hi_restore_o(mhi),
        .margin_lo_restore_o(mlo));

    cuor_host_model cuor_host_model_i (
        .ref_clk_i(clk), .rd_valid_i(rdv), .cmd_nack_i(nack),
        .rd_data_i(rdd), .cmd_valid_o(cv), .cmd_write_o(cw),
        .cmd_code_o(cc), .cmd_wdata_o(cd));

    always #25 clk = ~clk;

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic int depth(input logic [1:0] f);
        return (f == 2'h1) ? 1 : (f == 2'h2) ? 8 : (f == 2'h0) ? 16 : 32;
    endfunction

    function automatic cuor_div_t ediv(input logic [1:0] f,
                                       input cuor_scale_t s);
        if (f == 2'h3)
            return CUOR_DIV_HALF;
        if (f == 2'h2)
            return CUOR_DIV_QUARTER;
        if (f == 2'h1)
            return CUOR_DIV_EIGHTH;
        return cuor_div_t'(s);
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chkb(input string n, input logic e, input logic g);
        chk(n, {15'h0000, e}, {15'h0000, g});
    endtask

    task automatic wr(input logic [15:0] d);
        cuor_host_model_i.send(1'b1, 8'hE5, d);
    endtask

    task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
        cuor_host_model_i.send(1'b0, c, 16'h0000);
        chkb("read valid", 1'b1, cuor_host_model_i.rd_seen);
        chk($sformatf("read %h", c), e, cuor_host_model_i.rd_word);
    endtask

    task automatic smp(input int ch, input logic [11:0] d);
        @(posedge clk);
        smp_v  <= 1'b1;
        smp_ch <= cuor_chan_t'(ch);
        smp_d  <= d;
        @(posedge clk);
        smp_v  <= 1'b0;
        smp_d  <= ~d;
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev[k] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic reload(input logic e);
        int n;
        n = 0;
        @(posedge clk);
        ev[3] <= 1'b1;
        @(posedge clk);
        ev[3] <= 1'b0;
        repeat (4)
        begin
            @(negedge clk);
            n += int'(rld === 1'b1);
        end
        chk("reload pulses", {15'h0000, e}, 16'(n));
    endtask

    // The limit keeps a hung handshake from running the bench forever.
    always @(posedge clk)
    begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000)
        begin
            err_total++;
            end_of_test();
        end
    end

    initial
    begin
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] d;
        logic [31:0] r;
        logic [1:0]  fl;
        logic [11:0] v;
        int          ch;
        int          sum;
        clk = 1'b0;
        rst_n = 1'b0;
        smp_v = 1'b0;
        smp_ch = CUOR_CHAN_VOUT;
        smp_d = 12'h000;
        power_good_indication = 1'b1;
        rsrc = 1'b0;
        scale = CUOR_SCALE_HALF;
        ev = 4'h0;
        fault = 8'h00;
        hmask = 8'h00;
        seed = 32'h00000016;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(8'hE5, 16'h0184);
        chkb("neg limit", 1'b1, nil);
        chk("margin high", 16'h0009, mhi);
        chk("margin low", 16'hFFF7, mlo);
        // Depth codes 01, 10, 11, 00 in turn, rotating the channel.
        for (int f = 0; f < 4; f++)
        begin
            fl = 2'((f + 1) % 4);
            ch = f % 3;
            wr({9'h000, fl, 5'h04});
            sum = 0;
            for (int i = 0; i < depth(fl); i++)
            begin
                v = 12'(rnd());
                sum += int'(v);
                smp(ch, v);
            end
            rb[ch] = 12'(sum / depth(fl));
            rdchk(8'h8B + 8'(ch), {4'h0, rb[ch]});
        end
        wr(16'h0020);
        chkb("converter run", 1'b0, adc);
        smp(0, 12'hABC);
        smp(1, 12'h123);
        rdchk(8'h8B, {4'h0, rb[0]});
        rdchk(8'h8C, {4'h0, rb[1]});
        wr(16'h002C);
        smp(1, 12'h5A5);
        smp(2, 12'h3C3);
        rdchk(8'h8C, {4'h0, rb[1]});
        rdchk(8'h8D, {4'h0, rb[2]});
        smp(0, 12'h6D2);
        rdchk(8'h8B, 16'h06D2);
        a = 16'(rnd());
        b = 16'(rnd());
        wr(a);
        cuor_host_model_i.send(1'b1, 8'h11, 16'h0000);
        wr(b);
        cuor_host_model_i.send(1'b1, 8'h12, 16'h0000);
        rdchk(8'hE5, (a & `CUOR_OPT_NV_MASK) | (b & 16'h0018));
        cuor_host_model_i.send(1'b0, 8'h00, 16'h0000);
        chkb("nack", 1'b1, cuor_host_model_i.nack_seen);
        for (int i = 0; i < 12; i++)
        begin
            d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'(rnd());
            r = rnd();
            power_good_indication <= r[0];
            rsrc <= r[1];
            scale <= r[3] ? CUOR_SCALE_QUARTER :
                     (r[2] ? CUOR_SCALE_HALF : CUOR_SCALE_ONE);
            wr(d);
            rdchk(8'hE5, d & `CUOR_OPT_WR_MASK);
            chkb("neg limit", ~d[0], nil);
            chkb("shared pin", d[1] ? r[1] : r[0], pin);
            chkb("converter run", d[2], adc);
            chkb("fast mode", d[3], fast);
            chkb("override", d[4], ovr);
            chk("divider", {14'h0, ediv(d[9:8], scale)}, {14'h0, div});
            chk("margin high", d[14] ? 16'h000F : 16'h0009, mhi);
            chk("margin low", d[13] ? 16'hFFF1 : 16'hFFF7, mlo);
        end
        wr(16'h0084);
        fault <= 8'h01;
        repeat (3) @(posedge clk);
        chkb("alert", 1'b0, alrt);
        pulse(0);
        chkb("alert", 1'b1, alrt);
        pulse(1);
        chkb("alert", 1'b0, alrt);
        wr(16'h0004);
        pulse(0);
        chkb("alert", 1'b0, alrt);
        hmask <= 8'h01;
        repeat (3) @(posedge clk);
        chkb("alert", 1'b1, alrt);
        fault <= 8'h00;
        hmask <= 8'h00;
        wr(16'h0014);
        pulse(2);
        chkb("invalid flag", 1'b0, invalid_data_flag);
        chkb("alert", 1'b1, alrt);
        wr(16'h0004);
        repeat (3) @(posedge clk);
        chkb("alert", 1'b1, alrt);
        pulse(2);
        chkb("invalid flag", 1'b1, invalid_data_flag);
        chkb("alert", 1'b0, alrt);
        pulse(1);
        chkb("invalid flag", 1'b0, invalid_data_flag);
        wr(16'h0804);
        reload(1'b1);
        wr(16'h0004);
        reload(1'b0);
        end_of_test();
    end
endmodule // cuor_options_top_tb_top
